// ==== verilog/acc_coherent_cdc.sv ====
// coherent load write and counter read across bus and counter clocks
// What this block does
// - retime counter clock in bus domain and detect its rising edges
// - on counter clock rise copy pending flag into safe pending flag
// - on counter clock rise copy assembled value into safe load value
// - counter loads safe value on its edge while safe flag set
// - pending flag holds until returned toggle changes
// - toggle flips per new value; a change of the returned toggle clears both flags
// - asynchronous write stages partial bytes in shadows like other cases
// - lower bytes shadowed; upper byte write moves all into load value
// - byte 0 is trigger byte when counter is wider than bus
// - trigger read captures upper counter bytes into holding register
// - holding register omitted when counter fits one access
// - synchronous case: trigger read captures bits above first byte
// - upper byte reads come from holding register, not live counter
// - asynchronous read: counter sampled into shadow on each detected rise
// - asynchronous read: LSB from shadow, other bytes from holding
// - without read enable previous read data stays on read bus
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_coherent_cdc
	import acc_pkg::*;
#(
	parameter int           CNT_W   = `ACC_CNT_W,     // counter width
	parameter int           BUS_W   = `ACC_BUS_W,     // bus data width
	parameter acc_clk_rel_t CLK_REL = ACC_REL_ASYNC,  // clock relationship
	localparam int          NB      = (CNT_W + BUS_W - 1) / BUS_W,
	localparam int          SEL_W   = (NB > 1) ? $clog2(NB) : 1
)(
	input  wire logic             clock,                  // bus clock
	input  wire logic             nrst,                   // async reset, low
	input  wire logic             wr_en,                  // load byte write strobe
	input  wire logic [SEL_W-1:0] wr_lane,                // written lane index
	input  wire logic [BUS_W-1:0] wr_data,                // written lane data
	input  wire logic             rd_en,                  // counter read strobe
	input  wire logic [SEL_W-1:0] rd_lane,                // read lane index
	output logic      [BUS_W-1:0] rd_data,                // read-back data
	input  wire logic             counter_clock,          // counter clock level
	input  wire logic [CNT_W-1:0] live_counter_value,     // counter value
	input  wire logic             load_done_toggle,       // flips on each load
	output logic      [CNT_W-1:0] assembled_load_value,   // coherent load value
	output logic      [CNT_W-1:0] safe_load_value,        // load source
	output logic                  pending_load_flag,      // new value waiting
	output logic                  safe_pending_load_flag, // load qualifier
	output logic                  new_value_toggle        // flips per new value
);
	localparam int PAD_W = NB * BUS_W;
	localparam int TRIG  = `ACC_TRIGGER_LANE;
	localparam logic [SEL_W-1:0] TOP_LANE  = SEL_W'(NB - 1);
	localparam logic [SEL_W-1:0] TRIG_LANE = SEL_W'(TRIG);
	localparam logic no_coherency_needed   = (NB == 1);

	// ==========================================
	// counter clock and returned toggle retiming
	acc_edge_if cnt_edge ();
	acc_edge_if ack_edge ();

	assign cnt_edge.raw = counter_clock;
	assign ack_edge.raw = load_done_toggle;

	acc_edge_sync u_cnt_sync (
		.clock   (clock),
		.nrst    (nrst),
		.edge_io (cnt_edge)
	);

	acc_edge_sync u_ack_sync (
		.clock   (clock),
		.nrst    (nrst),
		.edge_io (ack_edge)
	);

	logic cnt_rise;
	logic ack_seen;

	assign cnt_rise = cnt_edge.rise;
	assign ack_seen = ack_edge.change;

	// ==========================================
	// write path: shadows, assembly and handover
	logic [PAD_W-1:0] wr_shadow;
	logic [PAD_W-1:0] next_wr_shadow;
	logic [CNT_W-1:0] next_assembled;
	logic [CNT_W-1:0] next_safe_value;
	logic             next_pending;
	logic             next_safe_pending;
	logic             next_toggle;
	logic             top_write;

	assign top_write = wr_en && (wr_lane == TOP_LANE);

	always_comb begin
		logic [PAD_W-1:0] merged;
		merged            = wr_shadow;
		next_wr_shadow    = wr_shadow;
		next_assembled    = assembled_load_value;
		next_safe_value   = safe_load_value;
		next_pending      = pending_load_flag;
		next_safe_pending = safe_pending_load_flag;
		next_toggle       = new_value_toggle;

		// lower lanes wait in shadows so the counter keeps the old value
		if (wr_en && !top_write && wr_lane < TOP_LANE) begin
			next_wr_shadow[int'(wr_lane) * BUS_W +: BUS_W] = wr_data;
		end

		if (top_write) begin
			merged[int'(TOP_LANE) * BUS_W +: BUS_W] = wr_data;
			next_assembled = merged[CNT_W-1:0];
			next_toggle    = ~new_value_toggle;
		end

		// a fresh write outranks a same-cycle acknowledge
		if (ack_seen) begin
			next_pending      = 1'h0;
			next_safe_pending = 1'h0;
		end else if (cnt_rise) begin
			next_safe_pending = pending_load_flag;
		end
		if (top_write) begin
			next_pending = 1'h1;
		end

		// copy after the edge, while the counter side is not sampling
		if (cnt_rise) begin
			next_safe_value = assembled_load_value;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_shadow              <= '0;
			assembled_load_value   <= '0;
			safe_load_value        <= '0;
			pending_load_flag      <= `ACC_RST_BIT;
			safe_pending_load_flag <= `ACC_RST_BIT;
			new_value_toggle       <= `ACC_RST_BIT;
		end else begin
			wr_shadow              <= next_wr_shadow;
			assembled_load_value   <= next_assembled;
			safe_load_value        <= next_safe_value;
			pending_load_flag      <= next_pending;
			safe_pending_load_flag <= next_safe_pending;
			new_value_toggle       <= next_toggle;
		end
	end

	// ==========================================
	// read path: sampled counter shadow
	logic [CNT_W-1:0] cnt_shadow;
	logic [CNT_W-1:0] next_cnt_shadow;
	logic [CNT_W-1:0] read_source;

	always_comb begin
		next_cnt_shadow = cnt_shadow;
		// counter value is stable just after its clock edge
		if (CLK_REL == ACC_REL_ASYNC && cnt_rise) begin
			next_cnt_shadow = live_counter_value;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_shadow <= '0;
		end else begin
			cnt_shadow <= next_cnt_shadow;
		end
	end

	assign read_source = (CLK_REL == ACC_REL_ASYNC) ? cnt_shadow : live_counter_value;

	// ==========================================
	// read path: holding register for upper lanes
	logic             trigger_byte_read_en;
	logic [PAD_W-1:0] upper_bytes_hold;

	assign trigger_byte_read_en = rd_en && (rd_lane == TRIG_LANE) && !no_coherency_needed;

	generate
		if (NB > 1) begin : g_hold
			logic [PAD_W-1:0] hold_q;
			logic [PAD_W-1:0] next_hold;

			always_comb begin
				next_hold = hold_q;
				// bits above the first lane, captured in one go
				if (trigger_byte_read_en) begin
					next_hold = '0;
					next_hold[CNT_W-1:BUS_W] = read_source[CNT_W-1:BUS_W];
				end
			end

			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					hold_q <= '0;
				end else begin
					hold_q <= next_hold;
				end
			end

			assign upper_bytes_hold = hold_q;
		end else begin : g_no_hold
			assign upper_bytes_hold = '0;
		end
	endgenerate

	// ==========================================
	// read data mux, held between reads
	logic [PAD_W-1:0] padded_source;
	logic [BUS_W-1:0] next_rd_data;

	assign padded_source = PAD_W'(read_source);

	always_comb begin
		next_rd_data = rd_data;
		if (rd_en) begin
			if (no_coherency_needed || rd_lane == TRIG_LANE) begin
				next_rd_data = padded_source[TRIG * BUS_W +: BUS_W];
			end else if (rd_lane <= TOP_LANE) begin
				next_rd_data = upper_bytes_hold[int'(rd_lane) * BUS_W +: BUS_W];
			end else begin
				next_rd_data = '0;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_data <= '0;
		end else begin
			rd_data <= next_rd_data;
		end
	end
endmodule

// ==== pkg/acc_consts.svh ====
// constants shared by the coherent counter crossing block
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

`define ACC_CNT_W          32
`define ACC_BUS_W          8
`define ACC_TRIGGER_LANE   0
`define ACC_SYNC_STAGES    2
`define ACC_RST_BIT        1'h0
`define ACC_REL_SYNC_CODE  2'h1
`define ACC_REL_ASYNC_CODE 2'h2

`endif

// ==== pkg/acc_pkg.sv ====
// types shared by the coherent counter crossing block
package acc_pkg;
`include "acc_consts.svh"

	// relationship of bus clock to counter clock
	typedef enum logic [1:0] {
		ACC_REL_SYNC  = `ACC_REL_SYNC_CODE,
		ACC_REL_ASYNC = `ACC_REL_ASYNC_CODE
	} acc_clk_rel_t;

endpackage

// ==== pkg/acc_edge_if.sv ====
// carrier between an edge synchroniser and its user
`timescale 1ns/1ps
interface acc_edge_if;
	logic raw;
	logic level;
	logic rise;
	logic change;

	modport sync (input raw, output level, output rise, output change);
	modport user (output raw, input level, input rise, input change);
endinterface

// ==== verilog/acc_edge_sync.sv ====
// two-stage synchroniser with rise and change detection
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_edge_sync
	import acc_pkg::*;
(
	input  wire logic clock,         // bus clock
	input  wire logic nrst,          // async reset, active low
	acc_edge_if.sync  edge_io        // raw in, detected edges out
);
	// ==========================================
	// synchroniser
	logic meta;
	logic stable;
	logic prev;
	logic next_meta;
	logic next_stable;
	logic next_prev;

	always_comb begin
		next_meta   = edge_io.raw;
		next_stable = meta;
		next_prev   = stable;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta   <= `ACC_RST_BIT;
			stable <= `ACC_RST_BIT;
			prev   <= `ACC_RST_BIT;
		end else begin
			meta   <= next_meta;
			stable <= next_stable;
			prev   <= next_prev;
		end
	end

	// ==========================================
	// edge compare, only after both stages
	assign edge_io.level  = stable;
	assign edge_io.rise   = stable & ~prev;
	assign edge_io.change = stable ^ prev;
endmodule

// ==== sim/acc_counter_model.sv ====
// counter-domain partner: free counter clock and loadable up counter
`timescale 1ns/1ps
module acc_counter_model (
	input  wire logic        nrst,                   // async reset, active low
	input  wire logic [31:0] safe_load_value,        // load source
	input  wire logic        safe_pending_load_flag, // load qualifier
	output logic             counter_clock,          // counter clock
	output logic      [31:0] live_counter_value,     // count
	output logic             load_done_toggle,       // flips per load
	output logic      [31:0] last_load               // last value loaded
);
	// 102 ns period drifts against the bus clock and keeps high time above a bus period
	initial begin
		counter_clock = 1'b0;
		forever #51 counter_clock = ~counter_clock;
	end
	always_ff @(posedge counter_clock or negedge nrst) begin
		if (!nrst) begin
			live_counter_value <= 32'h0;
			load_done_toggle   <= 1'h0;
			last_load          <= 32'h0;
		end else if (safe_pending_load_flag) begin
			live_counter_value <= safe_load_value;
			last_load          <= safe_load_value;
			load_done_toggle   <= ~load_done_toggle;
		end else begin
			live_counter_value <= live_counter_value + 32'h1;
		end
	end
endmodule

// ==== sim/acc_cdc_props.sv ====
// concurrent checks on the ports of the coherent counter crossing block
`timescale 1ns/1ps
module acc_cdc_props
	import acc_pkg::*;
#(
	parameter int  CNT_W = 32, // counter width
	parameter int  BUS_W = 8,  // bus width
	localparam int NB    = (CNT_W + BUS_W - 1) / BUS_W,
	localparam int SEL_W = (NB > 1) ? $clog2(NB) : 1
)(
	input wire logic             clock,                  // bus clock
	input wire logic             nrst,                   // reset
	input wire logic             wr_en,                  // write strobe
	input wire logic [SEL_W-1:0] wr_lane,                // write lane
	input wire logic [BUS_W-1:0] wr_data,                // write byte
	input wire logic             rd_en,                  // read strobe
	input wire logic [BUS_W-1:0] rd_data,                // read data
	input wire logic             load_done_toggle,       // ack toggle
	input wire logic [CNT_W-1:0] assembled_load_value,   // load value
	input wire logic [CNT_W-1:0] safe_load_value,        // safe load value
	input wire logic             pending_load_flag,      // pending
	input wire logic             safe_pending_load_flag, // safe pending
	input wire logic             new_value_toggle        // new value toggle
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic up_wr;
	assign up_wr = wr_en && (wr_lane == SEL_W'(NB - 1));
	a_pend_on_upper: assert property (up_wr |=> pending_load_flag)
		else $error("pending flag not raised");
	a_upper_byte_in: assert property (up_wr |=>
		assembled_load_value[CNT_W-1 -: BUS_W] == $past(wr_data)) else $error("upper byte lost");
	a_toggle_per_value: assert property (up_wr |=> new_value_toggle != $past(new_value_toggle))
		else $error("toggle did not flip");
	a_shadow_only: assert property (!up_wr |=>
		$stable(assembled_load_value) && $stable(new_value_toggle)) else $error("early load value");
	a_pend_until_ack: assert property ($fell(pending_load_flag) |->
		$past(load_done_toggle) != $past(load_done_toggle, 6)) else $error("pending cleared early");
	a_safe_copy: assert property ($changed(safe_load_value) |->
		safe_load_value == $past(assembled_load_value)) else $error("safe value mismatch");
	a_safe_flag_src: assert property ($rose(safe_pending_load_flag) |-> $past(pending_load_flag))
		else $error("safe flag without pending");
	a_flags_clear_both: assert property (safe_pending_load_flag |-> pending_load_flag)
		else $error("flags out of step");
	a_read_data_held: assert property (!rd_en |=> $stable(rd_data))
		else $error("read data moved");
endmodule
bind acc_coherent_cdc acc_cdc_props #(.CNT_W(CNT_W), .BUS_W(BUS_W)) u_acc_cdc_props (.clock,
	.nrst, .wr_en, .wr_lane, .wr_data, .rd_en, .rd_data, .load_done_toggle,
	.assembled_load_value, .safe_load_value, .pending_load_flag, .safe_pending_load_flag,
	.new_value_toggle);

// ==== sim/tb.sv ====
// self-checking bench for the coherent counter crossing block
`timescale 1ns/1ps
module tb;
	import acc_pkg::*;
	logic        clock, nrst, wr_en, rd_en, counter_clock, load_done_toggle;
	logic        pending_load_flag, safe_pending_load_flag, new_value_toggle;
	logic [1:0]  wr_lane, rd_lane;
	logic [7:0]  wr_data, rd_data, rd_data_sync;
	logic [31:0] sync_count;
	logic [31:0] live_counter_value, assembled_load_value, safe_load_value, last_load;
	int          fail_count, compares;

	acc_coherent_cdc u_acc_coherent_cdc (.clock, .nrst, .wr_en, .wr_lane, .wr_data, .rd_en,
		.rd_lane, .rd_data, .counter_clock, .live_counter_value, .load_done_toggle,
		.assembled_load_value, .safe_load_value, .pending_load_flag, .safe_pending_load_flag,
		.new_value_toggle);
	acc_counter_model u_acc_counter_model (.nrst, .safe_load_value, .safe_pending_load_flag,
		.counter_clock, .live_counter_value, .load_done_toggle, .last_load);
	// second copy in the synchronous read mode, counting on the bus clock
	acc_coherent_cdc #(.CLK_REL(ACC_REL_SYNC)) u_acc_coherent_cdc_sync (.clock, .nrst, .wr_en,
		.wr_lane, .wr_data, .rd_en, .rd_lane, .rd_data(rd_data_sync), .counter_clock,
		.live_counter_value(sync_count), .load_done_toggle, .assembled_load_value(),
		.safe_load_value(), .pending_load_flag(), .safe_pending_load_flag(),
		.new_value_toggle());

	// every byte moves each cycle, so a torn read cannot match
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) sync_count <= 32'h0;
		else sync_count <= sync_count + 32'h0101_0101;
	end

	always #12.5 clock = ~clock;

	// =========================================
	// helpers
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("Error %0t: %s", $time, msg);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic write_lanes(input logic [31:0] v, input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			@(negedge clock);
			wr_en = 1'b1;
			wr_lane = 2'(i);
			wr_data = v[8*i +: 8];
		end
		@(negedge clock);
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [1:0] lane, output logic [7:0] d);
		@(negedge clock);
		rd_en = 1'b1;
		rd_lane = lane;
		@(negedge clock);
		rd_en = 1'b0;
		d = rd_data;
	endtask

	// =========================================
	// scenarios
	task automatic t_load(input logic [31:0] v);
		logic t0;
		t0 = new_value_toggle;
		write_lanes(v, 0, 3);
		check(assembled_load_value === v && pending_load_flag === 1'b1, "not assembled");
		check(new_value_toggle === ~t0, "toggle stuck");
		// two counter periods after the upper byte, plus one negedge to look
		for (int i = 0; i < 9 && last_load !== v; i++) @(negedge clock);
		check(last_load === v && safe_load_value === v, "no load");
		check(pending_load_flag === 1'b1, "pending dropped before ack");
		for (int i = 0; i < 8 && pending_load_flag !== 1'b0; i++) @(negedge clock);
		check(!pending_load_flag && !safe_pending_load_flag, "flags stuck");
	endtask
	task automatic t_partial();
		write_lanes(32'hA5C3_3C5A, 0, 2);
		check(assembled_load_value === 32'h1234_5678 && !pending_load_flag, "early");
		write_lanes(32'hA5C3_3C5A, 3, 3);
		check(assembled_load_value === 32'hA5C3_3C5A, "merge lost");
		repeat (24) @(negedge clock);
	endtask
	task automatic t_read();
		logic [7:0]  b[4];
		logic [31:0] c0;
		for (int i = 0; i < 200 && live_counter_value[7:0] !== 8'hFE; i++) @(negedge clock);
		rd(2'h0, b[0]);
		c0 = live_counter_value;
		repeat (60) @(negedge clock);
		for (int i = 1; i < 4; i++) rd(2'(i), b[i]);
		check(c0 - {b[3], b[2], b[1], b[0]} <= 32'h2, "read not coherent");
		check(live_counter_value[31:24] === 8'h01, "counter stalled");
		rd(2'h0, b[0]);
		check(8'(live_counter_value[7:0] - b[0]) <= 8'h2, "shadow stale");
	endtask
	task automatic t_read_sync();
		logic [7:0]  b[4];
		logic [31:0] s0;
		s0 = 32'h0;
		for (int i = 0; i < 4; i++) begin
			@(negedge clock);
			rd_en = 1'b1;
			rd_lane = 2'(i);
			if (i == 0) s0 = sync_count;
			@(negedge clock);
			rd_en = 1'b0;
			b[i] = rd_data_sync;
		end
		check({b[3], b[2], b[1], b[0]} === s0, "sync read torn");
	endtask
	task automatic t_reset_mid();
		logic [7:0] d;
		write_lanes(32'h5A5A_0F0F, 0, 3);
		write_lanes(32'h5A5A_0F0F, 3, 3);
		@(negedge clock);
		nrst = 1'b0;
		@(negedge clock);
		check(!new_value_toggle && !pending_load_flag && !safe_pending_load_flag, "flags");
		check(safe_load_value === 32'h0 && assembled_load_value === 32'h0, "values");
		repeat (3) @(negedge clock);
		nrst = 1'b1;
		repeat (4) @(negedge clock);
		rd(2'h2, d);
		check(d === 8'h0, "hold kept");
	endtask

	// =========================================
	// main sequence and watchdog
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wr_lane = 2'h0;
		rd_lane = 2'h0;
		wr_data = 8'h00;
		fail_count = 0;
		compares = 0;
		repeat (16) @(negedge clock);
		check(assembled_load_value === 32'h0 && !pending_load_flag && rd_data === 8'h0, "rst");
		nrst = 1'b1;
		repeat (8) @(negedge clock);
		t_load(32'h1234_5678);
		t_partial();
		t_load(32'h00FF_FFF0);
		t_read();
		t_read_sync();
		t_reset_mid();
		give_verdict();
	end
	initial begin
		#100us;
		fail_count++;
		give_verdict();
	end
endmodule
